// File: design/conversion_start_bit_sequencer.sv
// conversion sequencer: mode register, channel select, successive approximation, result regs
// assumes an APB master on clk; the comparator decision arrives asynchronously on a pin
//
// The APB slave port and the register offsets were chosen for this implementation.
`include "conversion_start_bit_consts.svh"

module conversion_start_bit_sequencer #(
  parameter int SAMPLE_CYC = `CONVERSION_START_BIT_SAMPLE_CYC
) (
  input  wire logic                     clk,
  input  wire logic                     resetn,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [11:0]              paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire logic                     compAbove,
  output logic      [`CONVERSION_START_BIT_RES_W-1:0]   dacCode,
  output logic      [`CONVERSION_START_BIT_CHAN_W-1:0]  analogInputSel,
  output logic                          sampleHold,
  output logic                          converterPowerOn,
  output logic                          conversionDoneIrq,
  output conversion_start_bit_pkg::conversion_start_bit_state_e         convState
);
  import conversion_start_bit_pkg::*;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  function automatic logic hitOff(input logic [11:0] a, input logic [11:0] off);
    hitOff = (a == off);
  endfunction : hitOff

  logic accWr;
  logic accRd;
  logic modeWr;
  logic chanWr;
  logic resRd;
  logic mapped;

  // acting only with pready keeps a stretched access phase from writing twice
  assign accWr  = psel & penable & pready & pwrite;
  assign accRd  = psel & penable & pready & ~pwrite;
  assign modeWr = accWr & hitOff(paddr, `CONVERSION_START_BIT_OFF_MODE);
  assign chanWr = accWr & hitOff(paddr, `CONVERSION_START_BIT_OFF_CHAN);
  assign resRd  = accRd & (hitOff(paddr, `CONVERSION_START_BIT_OFF_WORD) | hitOff(paddr, `CONVERSION_START_BIT_OFF_HIGH));
  assign mapped = hitOff(paddr, `CONVERSION_START_BIT_OFF_MODE) | hitOff(paddr, `CONVERSION_START_BIT_OFF_CHAN)
                | hitOff(paddr, `CONVERSION_START_BIT_OFF_WORD) | hitOff(paddr, `CONVERSION_START_BIT_OFF_HIGH)
                | hitOff(paddr, `CONVERSION_START_BIT_OFF_STATUS);

  // ----------------------------------------------------------------
  // comparator synchroniser
  // ----------------------------------------------------------------
  // only the second flop is read; the first may still be settling
  logic compMeta_q;
  logic compSync_q;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      compMeta_q <= 1'b0;
      compSync_q <= 1'b0;
    end else begin
      compMeta_q <= compAbove;
      compSync_q <= compMeta_q;
    end
  end

  // ----------------------------------------------------------------
  // state, mode bits and approximation
  // ----------------------------------------------------------------
  conversion_start_bit_state_e                  state_q;
  logic                         power_q;
  logic                         start_q;
  logic [`CONVERSION_START_BIT_CHAN_W-1:0]      chan_q;
  logic [`CONVERSION_START_BIT_RES_W-1:0]       approx_q;
  logic [3:0]                   bitIdx_q;
  logic [7:0]                   sampleCnt_q;
  logic [7:0]                   stabCnt_q;
  logic                         finish;
  logic [`CONVERSION_START_BIT_RES_W-1:0]       finalCode;
  logic                         newPower;
  logic                         newStart;

  assign newPower = pwdata[`CONVERSION_START_BIT_BIT_POWER];
  assign newStart = pwdata[`CONVERSION_START_BIT_BIT_START];
  // last comparison resolves bit 0 this cycle
  assign finish   = (state_q == CONVERSION_START_BIT_CONVERTING) && (bitIdx_q == 4'h0);
  assign finalCode = compSync_q ? approx_q : (approx_q & ~(`CONVERSION_START_BIT_RES_W'(1) << bitIdx_q));

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_q     <= CONVERSION_START_BIT_STOPPED;
      power_q     <= 1'b0;
      start_q     <= 1'b0;
      approx_q    <= '0;
      bitIdx_q    <= 4'h0;
      sampleCnt_q <= 8'h00;
    end else if (modeWr) begin
      // a mode write takes priority over any completion in the same cycle
      power_q <= newPower;
      unique case (state_q)
        CONVERSION_START_BIT_STOPPED: begin
          start_q <= 1'b0;
          if (newPower) begin
            state_q <= CONVERSION_START_BIT_STANDBY;
          end
        end
        CONVERSION_START_BIT_STANDBY: begin
          if (!newPower) begin
            state_q <= CONVERSION_START_BIT_STOPPED;
            start_q <= 1'b0;
          end else if (newStart) begin
            start_q     <= 1'b1;
            state_q     <= CONVERSION_START_BIT_SAMPLING;
            sampleCnt_q <= 8'(SAMPLE_CYC - 1);
          end else begin
            start_q <= 1'b0;
          end
        end
        CONVERSION_START_BIT_SAMPLING, CONVERSION_START_BIT_CONVERTING: begin
          // a write that keeps start set holds the search for that one cycle
          if (!newStart || !newPower) begin
            start_q <= 1'b0;
            state_q <= newPower ? CONVERSION_START_BIT_STANDBY : CONVERSION_START_BIT_STOPPED;
          end else if (finish) begin
            // the write wins over the completing result, so the run ends without one
            start_q <= 1'b0;
            state_q <= CONVERSION_START_BIT_STANDBY;
          end
        end
      endcase
    end else begin
      unique case (state_q)
        CONVERSION_START_BIT_STOPPED, CONVERSION_START_BIT_STANDBY: begin
        end
        CONVERSION_START_BIT_SAMPLING: begin
          // counted down from SAMPLE_CYC-1, so the hold lasts SAMPLE_CYC cycles
          if (sampleCnt_q == 8'h00) begin
            state_q  <= CONVERSION_START_BIT_CONVERTING;
            bitIdx_q <= 4'(`CONVERSION_START_BIT_RES_W - 1);
            approx_q <= `CONVERSION_START_BIT_RES_W'(1) << (`CONVERSION_START_BIT_RES_W - 1);
          end else begin
            sampleCnt_q <= sampleCnt_q - 8'h01;
          end
        end
        CONVERSION_START_BIT_CONVERTING: begin
          if (finish) begin
            approx_q <= finalCode;
            start_q  <= 1'b0;
            state_q  <= CONVERSION_START_BIT_STANDBY;
          end else begin
            // keep or drop the trial bit, then try the next lower one
            approx_q <= finalCode | (`CONVERSION_START_BIT_RES_W'(1) << (bitIdx_q - 4'h1));
            bitIdx_q <= bitIdx_q - 4'h1;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // stabilisation counter, shown in status for software polling
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      stabCnt_q <= 8'h00;
    // saturates, so the flag stays up until the converter is stopped
    end else if (state_q == CONVERSION_START_BIT_STOPPED) begin
      stabCnt_q <= 8'h00;
    end else if (stabCnt_q != 8'(`CONVERSION_START_BIT_STAB_CYC)) begin
      stabCnt_q <= stabCnt_q + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // channel select, only taken while neither sampling nor converting
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      chan_q <= `CONVERSION_START_BIT_RST_CHAN;
    // a write while running is dropped, not deferred
    end else if (chanWr && !start_q) begin
      chan_q <= pwdata[`CONVERSION_START_BIT_CHAN_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // result registers; a pending result waits out a result read
  // ----------------------------------------------------------------
  logic [`CONVERSION_START_BIT_RES_W-1:0]  pendCode_q;
  logic                    pend_q;
  logic [`CONVERSION_START_BIT_WORD_W-1:0] word_q;
  logic [`CONVERSION_START_BIT_HIGH_W-1:0] high_q;
  logic                    done_q;
  logic                    doneEvt;
  logic                    haveCode;
  logic [`CONVERSION_START_BIT_RES_W-1:0]  useCode;

  assign doneEvt  = finish && !modeWr;
  assign haveCode = doneEvt | pend_q;
  assign useCode  = doneEvt ? finalCode : pendCode_q;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      word_q     <= `CONVERSION_START_BIT_RST_WORD;
      high_q     <= `CONVERSION_START_BIT_RST_HIGH;
      pend_q     <= 1'b0;
      pendCode_q <= '0;
      done_q     <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (haveCode && resRd) begin
        pend_q     <= 1'b1;
        pendCode_q <= useCode;
      end else if (haveCode) begin
        pend_q <= 1'b0;
        // left-justified: code times 64 in the word register
        word_q <= {useCode, `CONVERSION_START_BIT_WORD_SHIFT'(0)};
        high_q <= useCode[`CONVERSION_START_BIT_RES_W-1 -: `CONVERSION_START_BIT_HIGH_W];
        done_q <= 1'b1;
      end
      // an aborted conversion never reaches here, so results stay put
    end
  end

  assign conversionDoneIrq = done_q;

  // ----------------------------------------------------------------
  // APB slave: zero wait states, error on unmapped addresses
  // ----------------------------------------------------------------
  logic [31:0] rdMux;

  always_comb begin
    rdMux = 32'h0000_0000;
    unique case (paddr)
      `CONVERSION_START_BIT_OFF_MODE:   rdMux = {24'h0, start_q, 6'h00, power_q};
      `CONVERSION_START_BIT_OFF_CHAN:   rdMux = {28'h0, chan_q};
      `CONVERSION_START_BIT_OFF_WORD:   rdMux = {16'h0, word_q};
      `CONVERSION_START_BIT_OFF_HIGH:   rdMux = {24'h0, high_q};
      `CONVERSION_START_BIT_OFF_STATUS: rdMux = {28'h0, pend_q,
                                 stabCnt_q == 8'(`CONVERSION_START_BIT_STAB_CYC), state_q};
      default:          rdMux = 32'h0000_0000;
    endcase
  end

  // pready comes from a register set in the setup cycle, so each access phase takes one cycle
  // read data is taken at the setup edge, so a read never sees half a result update
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      prdata  <= (psel & ~penable & ~pwrite) ? rdMux : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // analog side outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      dacCode          <= '0;
      analogInputSel   <= `CONVERSION_START_BIT_RST_CHAN;
      sampleHold       <= 1'b0;
      converterPowerOn <= 1'b0;
      convState        <= CONVERSION_START_BIT_STOPPED;
    end else begin
      // trails the approximation by one cycle; the comparator sync adds two more
      dacCode          <= approx_q;
      analogInputSel   <= chan_q;
      sampleHold       <= (state_q == CONVERSION_START_BIT_SAMPLING);
      converterPowerOn <= power_q;
      convState        <= state_q;
    end
  end

endmodule : conversion_start_bit_sequencer

// File: design/conversion_start_bit_consts.svh
// register offsets, field positions, reset values and timing counts of the conversion sequencer
// assumes a 40 MHz peripheral clock and a 32-bit APB register bus
`ifndef CONVERSION_START_BIT_CONSTS_SVH
`define CONVERSION_START_BIT_CONSTS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define CONVERSION_START_BIT_OFF_MODE      12'h000
`define CONVERSION_START_BIT_OFF_CHAN      12'h004
`define CONVERSION_START_BIT_OFF_WORD      12'h008
`define CONVERSION_START_BIT_OFF_HIGH      12'h00C
`define CONVERSION_START_BIT_OFF_STATUS    12'h010

// ----------------------------------------------------------------
// field positions and widths
// ----------------------------------------------------------------
`define CONVERSION_START_BIT_BIT_POWER     0
`define CONVERSION_START_BIT_BIT_START     7
`define CONVERSION_START_BIT_CHAN_W        4
`define CONVERSION_START_BIT_RES_W         10
`define CONVERSION_START_BIT_WORD_W        16
`define CONVERSION_START_BIT_HIGH_W        8
`define CONVERSION_START_BIT_WORD_SHIFT    6

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CONVERSION_START_BIT_RST_WORD      16'h0000
`define CONVERSION_START_BIT_RST_HIGH      8'h00
`define CONVERSION_START_BIT_RST_CHAN      4'h0

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CONVERSION_START_BIT_CLK_HZ        40000000
`define CONVERSION_START_BIT_STAB_NS       125
// stabilisation wait is a least time, so round up; the sequencer counts it, status shows it
`define CONVERSION_START_BIT_STAB_CYC      ((`CONVERSION_START_BIT_STAB_NS * (`CONVERSION_START_BIT_CLK_HZ / 1000000) + 999) / 1000)
`define CONVERSION_START_BIT_SAMPLE_CYC    4

`endif

// File: design/conversion_start_bit_pkg.sv
// types shared by the conversion sequencer
// assumes the constants header is included alongside
package conversion_start_bit_pkg;

  typedef enum logic [1:0] {
    CONVERSION_START_BIT_STOPPED    = 2'b00,
    CONVERSION_START_BIT_STANDBY    = 2'b01,
    CONVERSION_START_BIT_SAMPLING   = 2'b10,
    CONVERSION_START_BIT_CONVERTING = 2'b11
  } conversion_start_bit_state_e;

endpackage : conversion_start_bit_pkg

// File: test/conversion_start_bit_seq_properties.sv
// concurrent checks on the conversion sequencer ports
// assumes a bind onto conversion_start_bit_sequencer, one clock and its synchronous reset
`include "conversion_start_bit_consts.svh"
module conversion_start_bit_seq_properties
  import conversion_start_bit_pkg::*;
#(
  parameter int SAMPLE_CYC = 4
) (
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        converterPowerOn,
  input wire logic        conversionDoneIrq,
  input wire conversion_start_bit_state_e convState
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // a mode write takes effect only at the completing access edge
  logic modeWr;
  assign modeWr = psel && penable && pready && pwrite && (paddr == `CONVERSION_START_BIT_OFF_MODE);

  AST_IRQ_PULSE: assert property (conversionDoneIrq |=> !conversionDoneIrq)
    else $error("done request lasted more than one cycle");
  AST_IRQ_FROM_CONV: assert property (conversionDoneIrq |-> $past(convState) == CONVERSION_START_BIT_CONVERTING)
    else $error("done request without a running conversion");
  AST_DONE_STANDBY: assert property (conversionDoneIrq |-> ##[0:1] convState == CONVERSION_START_BIT_STANDBY)
    else $error("no return to standby after completion");
  AST_POWER_ON: assert property (modeWr && convState == CONVERSION_START_BIT_STOPPED && pwdata[0] && !pwdata[7]
    |=> ##1 convState == CONVERSION_START_BIT_STANDBY)
    else $error("power-on write did not reach standby");
  AST_NO_START_STOPPED: assert property (convState == CONVERSION_START_BIT_STOPPED
    |=> convState inside {CONVERSION_START_BIT_STOPPED, CONVERSION_START_BIT_STANDBY})
    else $error("conversion began from stopped");
  AST_START: assert property (modeWr && convState == CONVERSION_START_BIT_STANDBY && pwdata[0] && pwdata[7]
    |=> ##1 convState == CONVERSION_START_BIT_SAMPLING)
    else $error("start write in standby did not begin sampling");
  AST_ABORT: assert property (modeWr && convState inside {CONVERSION_START_BIT_SAMPLING, CONVERSION_START_BIT_CONVERTING}
    && pwdata[0] && !pwdata[7] |=> !conversionDoneIrq ##1 convState == CONVERSION_START_BIT_STANDBY)
    else $error("abort did not reach standby quietly");
  AST_POWER_OFF: assert property (modeWr && convState == CONVERSION_START_BIT_STANDBY && !pwdata[0]
    |=> ##1 (convState == CONVERSION_START_BIT_STOPPED && !converterPowerOn))
    else $error("power-off in standby did not stop");
endmodule : conversion_start_bit_seq_properties

bind conversion_start_bit_sequencer conversion_start_bit_seq_properties #(.SAMPLE_CYC(SAMPLE_CYC)) chk_u (
  .clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .converterPowerOn(converterPowerOn),
  .conversionDoneIrq(conversionDoneIrq), .convState(convState)
);

// File: test/tb.sv
// self-checking bench for the conversion sequencer, APB master and comparator stand-in
// assumes the design sources and the properties checker are compiled before it
`include "conversion_start_bit_consts.svh"
module tb import conversion_start_bit_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic        compAbove = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rdata;
  logic        pready, pslverr, slvErr, sampleHold, converterPowerOn, conversionDoneIrq;
  logic [9:0]  dacCode;
  logic [3:0]  analogInputSel;
  conversion_start_bit_state_e convState;
  logic [15:0] lfsr = 16'h06DE;
  int          n_fail = 0;
  int          checked = 0;
  int          cyc = 0;
  int          expWord, expHigh;
  bit          got;
  localparam int SAMPLE_CYC = 4;

  conversion_start_bit_sequencer #(.SAMPLE_CYC(SAMPLE_CYC)) dut_u (
    .clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .compAbove(compAbove), .dacCode(dacCode), .analogInputSel(analogInputSel),
    .sampleHold(sampleHold), .converterPowerOn(converterPowerOn),
    .conversionDoneIrq(conversionDoneIrq), .convState(convState)
  );

  always #12.5 clk = ~clk;

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : give_verdict

  // a hang ends the run well beyond the few hundred cycles the tests need
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      give_verdict();
    end
  end

  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction : rnd

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  // entered just after an edge; two idle edges follow so that a registered output
  // changed by this access has settled when the caller looks at it
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rdata = prdata;
    slvErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : apb

  task automatic wait_done(input int limit);
    got = 0;
    for (int n = 0; n < limit && !got; n++) begin
      @(posedge clk);
      got = (conversionDoneIrq === 1'b1);
    end
  endtask : wait_done

  // comparator held steady for a whole conversion, so every trial bit resolves alike
  task automatic convert(input logic [3:0] ch, input logic hi);
    compAbove <= hi;
    apb(1'b1, `CONVERSION_START_BIT_OFF_CHAN, {28'h0, ch});
    apb(1'b1, `CONVERSION_START_BIT_OFF_MODE, 32'h81);
    check("channel", {28'h0, analogInputSel}, {28'h0, ch});
    wait_done(100);
    check("done", {31'h0, got}, 32'h1);
    expWord = (hi ? 1023 : 0) * 64;
    expHigh = (hi ? 1023 : 0) / 4;
    apb(1'b0, `CONVERSION_START_BIT_OFF_WORD, 32'h0);
    check("word", rdata, expWord);
    apb(1'b0, `CONVERSION_START_BIT_OFF_HIGH, 32'h0);
    check("high", rdata, expHigh);
    apb(1'b0, `CONVERSION_START_BIT_OFF_MODE, 32'h0);
    check("mode", rdata, 32'h1);
    check("state", 32'(convState), 32'(CONVERSION_START_BIT_STANDBY));
  endtask : convert

  initial begin
    logic [15:0] r;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    apb(1'b0, `CONVERSION_START_BIT_OFF_WORD, 32'h0);
    check("word", rdata, 32'h0);
    apb(1'b0, `CONVERSION_START_BIT_OFF_HIGH, 32'h0);
    check("high", rdata, 32'h0);
    apb(1'b0, 12'hFFC, 32'h0);
    check("slverr", {31'h0, slvErr}, 32'h1);
    $display("test reset values done");
    apb(1'b1, `CONVERSION_START_BIT_OFF_MODE, 32'h81);
    check("state", 32'(convState), 32'(CONVERSION_START_BIT_STANDBY));
    apb(1'b0, `CONVERSION_START_BIT_OFF_MODE, 32'h0);
    check("mode", rdata, 32'h1);
    apb(1'b1, `CONVERSION_START_BIT_OFF_MODE, 32'h0);
    check("state", 32'(convState), 32'(CONVERSION_START_BIT_STOPPED));
    $display("test start while stopped done");
    apb(1'b1, `CONVERSION_START_BIT_OFF_MODE, 32'h1);
    check("state", 32'(convState), 32'(CONVERSION_START_BIT_STANDBY));
    repeat (`CONVERSION_START_BIT_STAB_CYC) @(posedge clk);
    for (int i = 0; i < 4; i++) begin
      r = rnd();
      convert({1'b0, r[2:0]}, i[0]);
    end
    $display("test conversions done");
    compAbove <= 1'b0;
    apb(1'b1, `CONVERSION_START_BIT_OFF_MODE, 32'h81);
    repeat (3) @(posedge clk);
    apb(1'b1, `CONVERSION_START_BIT_OFF_MODE, 32'h1);
    check("state", 32'(convState), 32'(CONVERSION_START_BIT_STANDBY));
    wait_done(40);
    check("done", {31'h0, got}, 32'h0);
    apb(1'b0, `CONVERSION_START_BIT_OFF_WORD, 32'h0);
    check("word", rdata, expWord);
    $display("test abort done");
    // the next access edge lands on the last comparison: sampling, ten bits, four bus edges
    apb(1'b1, `CONVERSION_START_BIT_OFF_MODE, 32'h81);
    repeat (SAMPLE_CYC + `CONVERSION_START_BIT_RES_W - 4) @(posedge clk);
    apb(1'b1, `CONVERSION_START_BIT_OFF_MODE, 32'h1);
    wait_done(40);
    check("done", {31'h0, got}, 32'h0);
    apb(1'b0, `CONVERSION_START_BIT_OFF_WORD, 32'h0);
    check("word", rdata, expWord);
    check("state", 32'(convState), 32'(CONVERSION_START_BIT_STANDBY));
    $display("test mode write collision done");
    apb(1'b1, `CONVERSION_START_BIT_OFF_MODE, 32'h81);
    repeat (SAMPLE_CYC + `CONVERSION_START_BIT_RES_W - 4) @(posedge clk);
    apb(1'b0, `CONVERSION_START_BIT_OFF_WORD, 32'h0);
    check("word", rdata, expWord);
    apb(1'b0, `CONVERSION_START_BIT_OFF_WORD, 32'h0);
    check("word", rdata, 32'h0);
    $display("test read collision done");
    apb(1'b1, `CONVERSION_START_BIT_OFF_MODE, 32'h0);
    check("state", 32'(convState), 32'(CONVERSION_START_BIT_STOPPED));
    check("power", {31'h0, converterPowerOn}, 32'h0);
    $display("test power off done");
    give_verdict();
  end
endmodule : tb
